// >>> src/lfa_pkg.sv
// lfa_pkg: shared constants for the lock and fuse self-access block
// assumes a single 40 MHz core clock; no register bus, control bits are ports
package lfa_pkg;

  // self_program_ctrl_reg field positions
  localparam int unsigned SPE_BIT = 0;
  localparam int unsigned LAS_BIT = 3;
  // arming pattern X0001001, bit 7 is don't care
  localparam logic [6:0] LOCK_ARM_PAT = 7'h09;

  // arming windows, in cycles after the control write
  localparam logic [2:0] LOAD_WIN = 3'h3;
  localparam logic [2:0] STORE_WIN = 3'h4;

  // pointer values selecting the readback source
  localparam logic [15:0] PTR_FUSE_LO = 16'h0000;
  localparam logic [15:0] PTR_LOCK = 16'h0001;
  localparam logic [15:0] PTR_FUSE_HI = 16'h0003;

  // working register field holding the four boot protection bits
  localparam int unsigned BPROT_LSB = 2;
  localparam int unsigned BPROT_W = 4;
  localparam logic [3:0] BPROT_ERASED = 4'hf;
  localparam logic [1:0] UNSPEC_TOP = 2'h3;

  // write time, figures as printed, and derived cycle counts
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PROG_MIN_NS = 3700000;
  localparam int unsigned PROG_MAX_NS = 4500000;
  localparam int unsigned PROG_MIN_CYC = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_MAX_CYC = PROG_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PROG_CNT_W = 18;

endpackage

// >>> src/lfa_arm_window.sv
// lfa_arm_window: counts cycles since the arming write
// assumes start and stop are same-clock pulses from the control logic
`timescale 1ns/1ps
`default_nettype none
module lfa_arm_window
  import lfa_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic stop,
  output logic load_ok,
  output logic store_ok,
  output logic expire
);

  logic running;
  logic [2:0] age;
  logic next_running;
  logic [2:0] next_age;

  always_comb begin
    next_running = running;
    next_age = age;
    if (start) begin
      next_running = 1'b1;
      next_age = 3'h0;
    end else if (stop || expire) begin
      next_running = 1'b0;
    end else if (running) begin
      next_age = age + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      age <= 3'h0;
    end else if (clk_en) begin
      running <= next_running;
      age <= next_age;
    end
  end

  // age 0 is the first cycle after the write
  assign load_ok = running && (age < LOAD_WIN);
  assign store_ok = running && (age < STORE_WIN);
  assign expire = running && (age == STORE_WIN - 3'h1);

endmodule
`default_nettype wire

// >>> src/lfa_prog_timer.sv
// lfa_prog_timer: times one protection-bit write
// assumes the cycle count stands for the oscillator-timed write interval
`timescale 1ns/1ps
`default_nettype none
module lfa_prog_timer
  import lfa_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic start,
  output logic busy,
  output logic done
);

  // the count must fit the counter and be at least one cycle
  if (CYCLES < 1 || CYCLES > (2 ** PROG_CNT_W) - 1) begin : g_bad_cycles
    $error("CYCLES does not fit the counter");
  end

  logic [PROG_CNT_W-1:0] remain;
  logic [PROG_CNT_W-1:0] next_remain;

  always_comb begin
    next_remain = remain;
    if (start && !busy) begin
      next_remain = PROG_CNT_W'(CYCLES);
    end else if (busy) begin
      next_remain = remain - PROG_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      remain <= '0;
    end else if (clk_en) begin
      remain <= next_remain;
    end
  end

  assign busy = (remain != '0);
  assign done = (remain == PROG_CNT_W'(1));

endmodule
`default_nettype wire

// >>> src/lfa_lock_fuse_access.sv
// lfa_lock_fuse_access: armed store and load windows for protection and fuse bits
// assumes core strobes are single-cycle pulses on sys_clk; eeprom busy is same-clock
//
// Function
// - timely store programs each boot protection bit whose source bit is zero
// - pointer contents are ignored for a protection-bit write
// - program memory stays readable, fetch never stalls during protection write
// - eeprom write in progress blocks protection-bit writes
// - eeprom write in progress blocks fuse and protection readback
// - armed, pointer 0001, load within three cycles returns protection bits
// - readback puts boot bits at 5..2, general bits at 1..0
// - arming bits auto-clear on readback, or when windows expire
// - with arming bits clear, load reads program memory normally
// - armed, pointer 0000, timely load returns low fuse byte
// - armed, pointer 0003, timely load returns high fuse byte
// - programmed bits read zero, unprogrammed bits read one
// - interrupt enabled: level request while self-program enable is clear
// - protection write lasts PROG_CYCLES cycles, 3.7 ms by default; only the 4.5 ms upper limit is enforced
`timescale 1ns/1ps
`default_nettype none
module lfa_lock_fuse_access
  import lfa_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_MIN_CYC,
  parameter logic [3:0] BPROT_INIT = BPROT_ERASED
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic store_prog,
  input wire logic load_prog,
  input wire logic [15:0] pointer,
  input wire logic [7:0] low_working_register,
  input wire logic eeprom_write_busy,
  input wire logic spm_int_en,
  input wire logic [1:0] general_prot,
  input wire logic [7:0] fuse_low_byte,
  input wire logic [7:0] fuse_high_byte,
  output logic [7:0] ctrl_rdata,
  output logic load_valid,
  output logic load_special,
  output logic [7:0] load_data,
  output logic prog_busy,
  output logic fetch_stall,
  output logic spm_irq,
  output logic [3:0] boot_prot
);

  // a longer write would break the documented upper limit, zero would never start the timer or apply the bits
  if (PROG_CYCLES < 1 || PROG_CYCLES > PROG_MAX_CYC) begin : g_bad_cycles
    $error("PROG_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // window and write timers

  logic win_start;
  logic win_stop;
  logic load_ok;
  logic store_ok;
  logic expire;
  logic prog_start;
  logic tmr_busy;
  logic tmr_done;

  lfa_arm_window u_window (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(win_start),
    .stop(win_stop),
    .load_ok(load_ok),
    .store_ok(store_ok),
    .expire(expire)
  );

  lfa_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(prog_start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control bits and the pending write pattern

  logic spe;
  logic las;
  logic [3:0] pend;
  logic [3:0] prot;
  logic next_spe;
  logic next_las;
  logic [3:0] next_pend;
  logic [3:0] next_prot;
  logic armed;
  logic take_store;
  logic take_load;

  assign armed = spe && las && !tmr_busy;
  assign take_store = armed && store_prog && store_ok;
  assign take_load = armed && load_prog && load_ok;

  always_comb begin
    next_spe = spe;
    next_las = las;
    next_pend = pend;
    next_prot = prot;
    win_start = 1'b0;
    win_stop = 1'b0;
    prog_start = 1'b0;
    if (tmr_busy) begin
      // enable stays up for the whole write; done drops it so the irq fires
      if (tmr_done) begin
        next_prot = prot & pend;
        next_spe = 1'b0;
        next_las = 1'b0;
      end
    end else if (ctrl_wr) begin
      next_spe = ctrl_wdata[SPE_BIT];
      next_las = ctrl_wdata[LAS_BIT];
      win_start = (ctrl_wdata[6:0] == LOCK_ARM_PAT);
    end else if (take_store) begin
      win_stop = 1'b1;
      if (eeprom_write_busy) begin
        next_spe = 1'b0;
        next_las = 1'b0;
      end else begin
        // the pointer is not looked at here
        next_pend = low_working_register[BPROT_LSB +: BPROT_W];
        prog_start = 1'b1;
      end
    end else if (take_load) begin
      win_stop = 1'b1;
      next_spe = 1'b0;
      next_las = 1'b0;
    end else if (armed && expire) begin
      next_spe = 1'b0;
      next_las = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      spe <= 1'b0;
      las <= 1'b0;
      pend <= BPROT_ERASED;
      prot <= BPROT_INIT;
    end else if (clk_en) begin
      spe <= next_spe;
      las <= next_las;
      pend <= next_pend;
      prot <= next_prot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback path

  function automatic logic [8:0] pick_source(input logic [15:0] ptr, input logic [3:0] bp,
                                             input logic [1:0] gp, input logic [7:0] flo,
                                             input logic [7:0] fhi);
    logic [8:0] r;
    r = 9'h000;
    unique case (ptr)
      PTR_LOCK: r = {1'b1, UNSPEC_TOP, bp, gp};
      PTR_FUSE_LO: r = {1'b1, flo};
      PTR_FUSE_HI: r = {1'b1, fhi};
      default: r = 9'h000;
    endcase
    return r;
  endfunction

  logic [8:0] src;
  logic next_valid;
  logic next_special;
  logic [7:0] next_data;
  logic next_irq;
  logic next_busy;
  logic [7:0] next_rdata;

  assign src = pick_source(pointer, prot, general_prot, fuse_low_byte, fuse_high_byte);

  always_comb begin
    next_valid = load_prog;
    next_special = 1'b0;
    next_data = 8'h00;
    // unarmed or busy loads fall through to ordinary memory reads
    if (take_load && !eeprom_write_busy && src[8]) begin
      next_special = 1'b1;
      next_data = src[7:0];
    end
    next_irq = spm_int_en && !next_spe;
    next_rdata = 8'h00;
    next_rdata[SPE_BIT] = next_spe;
    next_rdata[LAS_BIT] = next_las;
    // busy falls on the edge that applies the bits, so it never outlasts the write
    next_busy = prog_start || (tmr_busy && !tmr_done);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_valid <= 1'b0;
      load_special <= 1'b0;
      load_data <= 8'h00;
      spm_irq <= 1'b0;
      ctrl_rdata <= 8'h00;
      prog_busy <= 1'b0;
      fetch_stall <= 1'b0;
      boot_prot <= BPROT_INIT;
    end else if (clk_en) begin
      load_valid <= next_valid;
      load_special <= next_special;
      load_data <= next_data;
      spm_irq <= next_irq;
      ctrl_rdata <= next_rdata;
      prog_busy <= next_busy;
      fetch_stall <= 1'b0; // protection writes never hold the fetch path
      boot_prot <= next_prot;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_store_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_store && eeprom_write_busy |=> !prog_busy)
    else $error("store started while eeprom busy");

  chk_load_blocked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && load_prog && eeprom_write_busy |=> !load_special)
    else $error("readback during eeprom write");

  chk_lock_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_load && !eeprom_write_busy && pointer == PTR_LOCK
    |=> load_special && load_data[5:0] == {$past(prot), $past(general_prot)})
    else $error("lock readback wrong");

  chk_fuse_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_load && !eeprom_write_busy && pointer == PTR_FUSE_LO
    |=> load_special && load_data == $past(fuse_low_byte))
    else $error("low fuse readback wrong");

  chk_fuse_high: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_load && !eeprom_write_busy && pointer == PTR_FUSE_HI
    |=> load_special && load_data == $past(fuse_high_byte))
    else $error("high fuse readback wrong");

  // a store in the last window cycle only shows busy one cycle later, so look there
  chk_arm_expire: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && ctrl_wr && !tmr_busy && ctrl_wdata[6:0] == LOCK_ARM_PAT
    ##1 (clk_en && !ctrl_wr)[*4] ##1 !prog_busy |-> ctrl_rdata[0] == 1'b0)
    else $error("arming did not clear after window");

  chk_unarmed_load: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && load_prog && !(spe && las) |=> load_valid && !load_special)
    else $error("unarmed load treated as special");

  chk_no_change: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && !tmr_busy && !prog_start |=> boot_prot == $past(boot_prot))
    else $error("protection changed without write");

  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && spm_int_en |=> spm_irq == !ctrl_rdata[SPE_BIT])
    else $error("irq missing while enable clear");

  chk_unarmed_store: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && store_prog && !prog_busy && !(ctrl_rdata[SPE_BIT] && ctrl_rdata[LAS_BIT])
    |=> !prog_busy)
    else $error("unarmed store started a write");

  chk_busy_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_store && !eeprom_write_busy |=> prog_busy && ctrl_rdata[SPE_BIT])
    else $error("accepted store did not start a write");

  // the enable bit must already be clear in the first cycle after busy drops
  chk_busy_end: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && prog_busy ##1 !prog_busy |-> ctrl_rdata[SPE_BIT] == 1'b0)
    else $error("enable bit left set after write");

  chk_load_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && load_prog |=> load_valid)
    else $error("load not answered next cycle");

  chk_top_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && take_load && !eeprom_write_busy && pointer == PTR_LOCK
    |=> load_data[7:6] == UNSPEC_TOP)
    else $error("lock readback top bits wrong");

  chk_no_stall: assert property (@(posedge sys_clk) disable iff (!reset_n)
    prog_busy |-> !fetch_stall)
    else $error("fetch stalled during write");

endmodule
`default_nettype wire

// >>> bench/lfa_core_model.sv
// lfa_core_model: processor core issuing timed control, store and load strobes
// assumes the bench calls its tasks and sys_clk is the block clock
`timescale 1ns/1ps
`default_nettype none
module lfa_core_model (
  input wire logic sys_clk,
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata,
  output logic store_prog,
  output logic load_prog,
  output logic [15:0] pointer,
  output logic [7:0] low_working_register,
  output logic eeprom_write_busy
);
  // polls that ran out of patience, read by the bench at the end
  int stuck = 0;

  initial begin
    ctrl_wr = 1'b0;
    ctrl_wdata = 8'h00;
    store_prog = 1'b0;
    load_prog = 1'b0;
    pointer = 16'h0001;
    low_working_register = 8'hff;
    eeprom_write_busy = 1'b0;
  end

  task automatic ee(input logic b);
    eeprom_write_busy = b;
  endtask

  // st selects store or load, k is the cycle after the control write
  task automatic op(input logic st, input int k, input logic [15:0] ptr,
                    input logic [7:0] wr, input logic arm, input logic poll);
    int n;
    n = 0;
    // polling is skipped on purpose when a blocked access is wanted
    while (poll && eeprom_write_busy && n < 64) begin
      @(posedge sys_clk);
      n++;
    end
    if (poll && eeprom_write_busy) begin
      stuck++;
    end
    @(posedge sys_clk);
    #2;
    ctrl_wr = arm;
    ctrl_wdata = 8'h89; // don't-care bit set high
    @(posedge sys_clk);
    #2;
    ctrl_wr = 1'b0;
    repeat (k - 1) begin
      @(posedge sys_clk);
      #2;
    end
    pointer = ptr;
    low_working_register = wr | 8'hc3; // spare bits kept at one
    store_prog = st; // strobe in cycle k after the control write
    load_prog = !st;
    @(posedge sys_clk);
    #2;
    // return while the one-cycle load answer still stands
    store_prog = 1'b0;
    load_prog = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// tb_top: table-driven readback checks, then hand-written store and reset cases
// assumes a short write time parameter so the run stays brief
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lfa_pkg::*;
  typedef struct {logic [15:0] ptr; int k; logic eb; logic sp; logic [7:0] dat;} lfa_row_s;
  localparam int unsigned PCYC = 8;
  logic sys_clk, reset_n, spm_int_en;
  wire logic ctrl_wr, store_prog, load_prog, eeprom_write_busy;
  wire logic [7:0] ctrl_wdata, low_working_register;
  wire logic [15:0] pointer;
  logic [1:0] gp = 2'h1;
  logic [7:0] flo = 8'h5a;
  logic [7:0] fhi = 8'hc3;
  logic [7:0] ctrl_rdata, load_data;
  logic load_valid, load_special, prog_busy, fetch_stall, spm_irq;
  logic [3:0] boot_prot;
  int failures, checks, n;
  lfa_row_s rows [6];

  lfa_core_model core (.sys_clk(sys_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .store_prog(store_prog), .load_prog(load_prog), .pointer(pointer),
    .low_working_register(low_working_register), .eeprom_write_busy(eeprom_write_busy));

  lfa_lock_fuse_access #(.PROG_CYCLES(PCYC)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(1'b1), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .store_prog(store_prog),
    .load_prog(load_prog), .pointer(pointer), .low_working_register(low_working_register),
    .eeprom_write_busy(eeprom_write_busy), .spm_int_en(spm_int_en), .general_prot(gp),
    .fuse_low_byte(flo), .fuse_high_byte(fhi), .ctrl_rdata(ctrl_rdata),
    .load_valid(load_valid), .load_special(load_special), .load_data(load_data),
    .prog_busy(prog_busy), .fetch_stall(fetch_stall), .spm_irq(spm_irq),
    .boot_prot(boot_prot));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic wrap_up;
    failures = failures + core.stuck;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    spm_int_en = 1'b1;
    rows = '{'{16'h0001, 1, 1'b0, 1'b1, {UNSPEC_TOP, BPROT_ERASED, 2'h1}},
             '{16'h0000, 2, 1'b0, 1'b1, 8'h5a}, '{16'h0003, 3, 1'b0, 1'b1, 8'hc3},
             '{16'h0001, 4, 1'b0, 1'b0, 8'h00}, '{16'h0002, 1, 1'b0, 1'b0, 8'h00},
             '{16'h0000, 1, 1'b1, 1'b0, 8'h00}};
    repeat (5) @(posedge sys_clk);
    #2;
    chk_byte("reset boot_prot", {4'h0, BPROT_ERASED}, {4'h0, boot_prot});
    chk_bit("reset prog_busy", 1'b0, prog_busy);
    reset_n = 1'b1;
    // bit patterns in the fuse inputs: zeros are programmed cells
    foreach (rows[i]) begin
      core.ee(rows[i].eb);
      core.op(1'b0, rows[i].k, rows[i].ptr, 8'h00, 1'b1, 1'b0);
      chk_bit("load_valid", 1'b1, load_valid);
      chk_bit("load_special", rows[i].sp, load_special);
      chk_byte("load_data", rows[i].dat, load_data);
    end
    core.ee(1'b0);
    core.op(1'b0, 1, 16'h0001, 8'h00, 1'b1, 1'b1);
    chk_byte("ctrl_rdata after read", 8'h00, ctrl_rdata);
    core.op(1'b0, 1, 16'h0001, 8'h00, 1'b0, 1'b1);
    chk_bit("unarmed load_special", 1'b0, load_special);
    chk_bit("idle spm_irq", 1'b1, spm_irq);
    spm_int_en = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2;
    chk_bit("masked spm_irq", 1'b0, spm_irq);
    spm_int_en = 1'b1;
    // pointer left off its recommended value on purpose
    core.op(1'b1, 4, 16'h1234, 8'h14, 1'b1, 1'b1);
    chk_bit("prog_busy", 1'b1, prog_busy);
    chk_bit("fetch_stall", 1'b0, fetch_stall);
    chk_byte("busy ctrl_rdata", 8'h09, ctrl_rdata);
    n = 1;
    while (prog_busy === 1'b1) begin
      @(posedge sys_clk);
      #2;
      if (prog_busy === 1'b1) n++;
      if (n > 40) begin
        failures++;
        wrap_up();
      end
    end
    chk_byte("busy cycles", PCYC[7:0], n[7:0]);
    chk_byte("boot_prot", 8'h05, {4'h0, boot_prot});
    chk_byte("ctrl_rdata after write", 8'h00, ctrl_rdata);
    core.ee(1'b1);
    core.op(1'b1, 1, 16'h0001, 8'h00, 1'b1, 1'b0);
    chk_bit("blocked prog_busy", 1'b0, prog_busy);
    core.ee(1'b0);
    core.op(1'b1, 2, 16'h0001, 8'h00, 1'b0, 1'b1);
    chk_bit("unarmed prog_busy", 1'b0, prog_busy);
    chk_byte("kept boot_prot", 8'h05, {4'h0, boot_prot});
    core.op(1'b0, 3, 16'h0001, 8'h00, 1'b1, 1'b1);
    chk_byte("lock readback", {UNSPEC_TOP, 4'h5, 2'h1}, load_data);
    reset_n = 1'b0;
    #5;
    chk_byte("rereset boot_prot", {4'h0, BPROT_ERASED}, {4'h0, boot_prot});
    chk_bit("rereset prog_busy", 1'b0, prog_busy);
    @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    @(posedge sys_clk);
    #2;
    chk_bit("spm_irq after release", 1'b1, spm_irq);
    chk_bit("load_valid after release", 1'b0, load_valid);
    core.op(1'b0, 1, 16'h0001, 8'h00, 1'b1, 1'b1);
    chk_byte("lock after rereset", {UNSPEC_TOP, BPROT_ERASED, 2'h1}, load_data);
    wrap_up();
  end
endmodule
`default_nettype wire
